// >>> rtl/sera_line_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sera_line_sync
   import sera_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // pins
   input  wire logic scl_pin,
   input  wire logic sda_pin,
   // synchronised events
   output logic      sda,
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start_det,
   output logic      stop_det
);
   logic scl_m, scl_s, scl_d;
   logic sda_m, sda_s, sda_d;

   // idle bus is high, so reset to high to avoid false edges
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= scl_pin;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_pin;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   assign sda       = sda_s;
   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
endmodule // sera_line_sync
`default_nettype wire

// >>> rtl/sera_nv_array.sv
`timescale 1ns/100ps
`default_nettype none
module sera_nv_array
   import sera_pkg::*;
#(
   parameter int ERASE_CYC = ERASE_CYCLES,
   parameter int WRITE_CYC = WRITE_CYCLES
)(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // read port
   input  wire logic [ROW_W-1:0]  rd_row,
   output logic      [WORD_W-1:0] rd_data,
   // program port
   input  wire logic              prog_go,
   input  wire logic [ROW_W-1:0]  prog_row,
   input  wire logic [WORD_W-1:0] prog_data,
   input  wire logic              prog_fill,
   input  wire logic              prog_fill_val,
   output logic                   busy
);
   logic [WORD_W-1:0] mem      [ROWS];
   logic [WORD_W-1:0] next_mem [ROWS];
   sera_prog_e        state, next_state;
   logic [31:0]       cnt, next_cnt;
   logic [ROW_W-1:0]  row, next_row;
   logic [WORD_W-1:0] data, next_data;
   logic              fill, next_fill;
   logic              fill_val, next_fill_val;

   assign rd_data = mem[rd_row];
   assign busy    = (state != PG_IDLE);

   always_comb begin
      next_mem      = mem;
      next_state    = state;
      next_cnt      = cnt + 32'h0000_0001;
      next_row      = row;
      next_data     = data;
      next_fill     = fill;
      next_fill_val = fill_val;
      unique case (state)
         PG_IDLE: begin
            next_cnt = 32'h0000_0000;
            if (prog_go) begin
               next_state    = PG_ERASE;
               next_row      = prog_row;
               next_data     = prog_data;
               next_fill     = prog_fill;
               next_fill_val = prog_fill_val;
            end
         end
         PG_ERASE: begin
            if (cnt == 32'(ERASE_CYC - 1)) begin
               next_cnt   = 32'h0000_0000;
               next_state = PG_WRITE;
               for (int i = 0; i < ROWS; i++) begin
                  if (fill || (5'(i) == row)) next_mem[i] = WORD_RESET;
               end
            end
         end
         PG_WRITE: begin
            if (cnt == 32'(WRITE_CYC - 1)) begin
               next_state = PG_IDLE;
               if (fill) begin
                  for (int i = 0; i < ROWS; i++) next_mem[i] = {WORD_W{fill_val}};
               end else begin
                  next_mem[row] = data;
               end
            end
         end
      endcase
   end

   // storage starts from a known blank so simulation never reads unknowns
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mem      <= '{default: WORD_RESET};
         state    <= PG_IDLE;
         cnt      <= 32'h0000_0000;
         row      <= '0;
         data     <= WORD_RESET;
         fill     <= 1'b0;
         fill_val <= 1'b0;
      end else begin
         mem      <= next_mem;
         state    <= next_state;
         cnt      <= next_cnt;
         row      <= next_row;
         data     <= next_data;
         fill     <= next_fill;
         fill_val <= next_fill_val;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   property p_row_prog;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == PG_WRITE && cnt == 32'(WRITE_CYC - 1) && !fill) |=> (mem[$past(row)] == $past(data));
   endproperty
   a_row_prog: assert property (p_row_prog) else $error("row not programmed with buffer");

   property p_fill_all;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == PG_WRITE && cnt == 32'(WRITE_CYC - 1) && fill)
         |=> (mem[0] == {WORD_W{$past(fill_val)}}) && (mem[ROWS-1] == {WORD_W{$past(fill_val)}});
   endproperty
   a_fill_all: assert property (p_fill_all) else $error("array fill incomplete");

   property p_busy_span;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(busy) |-> busy [*2];
   endproperty
   a_busy_span: assert property (p_busy_span) else $error("program cycle too short");

   c_fill: cover property (@(posedge ref_clk) disable iff (!rst_n) prog_go && prog_fill);
endmodule // sera_nv_array
`default_nettype wire

// >>> rtl/sera_pkg.sv
`default_nettype none
package sera_pkg;
   // ****************************************
   // array geometry and control byte layout
   // ****************************************
   localparam int ROWS       = 32;
   localparam int ROW_W      = 5;
   localparam int WORD_W     = 16;
   localparam int CB_ROW_LSB = 3;
   localparam int CB_ORD_HI  = 2;
   localparam int CB_ORD_LO  = 1;
   localparam int CB_DIR     = 0;

   // order field {order_sel_hi, order_sel_lo}
   localparam logic [1:0] ORD_HI_LO = 2'h0;
   localparam logic [1:0] ORD_LO_HI = 2'h1;
   localparam logic [1:0] ORD_INC   = 2'h2;
   localparam logic [1:0] ORD_DEC   = 2'h3;

   localparam logic [3:0]  BYTE_BITS   = 4'h8;
   localparam logic [3:0]  LAST_TX_BIT = 4'h7;
   localparam logic [1:0]  MAX_WR_BYTES = 2'h2;
   localparam logic [15:0] WORD_RESET  = 16'h0000;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int ERASE_TIME_NS = 5000000;
   localparam int WRITE_TIME_NS = 5000000;
   localparam int ERASE_CYCLES  = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************
   // state types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE, ST_CTRL, ST_CACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
   } sera_link_e;

   typedef enum logic [1:0] {
      PG_IDLE, PG_ERASE, PG_WRITE
   } sera_prog_e;
endpackage
`default_nettype wire

// >>> rtl/sera_top.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - store 512 bits as 32 rows of one 16-bit word.
// - accept one or two byte writes, reads of any length.
// - control byte bit 0: zero writes, one reads.
// - five row bits pick one of 32 rows.
// - whole selected row is copied into a 16-bit staging buffer.
// - order bits choose high-then-low or low-then-high byte transfer.
// - reads may step rows upward or downward without new addresses.
// - two control codes fill whole array with zeros or ones.
// - control byte loads row; data bytes overwrite buffer in order.
// - while programming, inputs ignored and nothing acknowledged.
// - control byte is row[7:3], order bits [2:1], direction bit 0.
// - START wakes interface, STOP returns to standby, line released.
// - no master acknowledge stops transmission, back to receive.
module sera_top
   import sera_pkg::*;
#(
   parameter int ERASE_CYC = ERASE_CYCLES,
   parameter int WRITE_CYC = WRITE_CYCLES
)(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // serial pins, data line is open drain
   input  wire logic scl_pin,
   input  wire logic sda_pin_in,
   output logic      sda_pin_out,
   output logic      sda_pin_oe,
   // status
   output logic      prog_busy
);
   // ****************************************
   // pin conditioning
   // ****************************************
   logic sda, scl_rise, scl_fall, start_det, stop_det;

   sera_line_sync u_sync (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .scl_pin   (scl_pin),
      .sda_pin   (sda_pin_in),
      .sda       (sda),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det)
   );

   // ****************************************
   // link state
   // ****************************************
   sera_link_e        state, next_state;
   logic [7:0]        shreg, next_shreg;
   logic [3:0]        bit_cnt, next_bit_cnt;
   logic [7:0]        ctrl, next_ctrl;
   logic [ROW_W-1:0]  row, next_row;
   logic [WORD_W-1:0] buffer, next_buffer;
   logic              byte_idx, next_byte_idx;
   logic [1:0]        wr_cnt, next_wr_cnt;
   logic              sda_oe, next_sda_oe;
   logic              prog_go;
   logic [WORD_W-1:0] rd_data;
   logic              busy;

   // ****************************************
   // control byte decode
   // ****************************************
   logic [1:0] order;
   logic       dir_bit;
   logic       hi_first;
   logic       fill;
   logic       hi_slot;
   logic [7:0] tx_byte;

   assign order    = ctrl[CB_ORD_HI:CB_ORD_LO];
   assign dir_bit  = ctrl[CB_DIR];
   assign hi_first = (order != ORD_LO_HI);
   // fill codes are write bytes with order_sel_hi set
   assign fill     = !dir_bit && ctrl[CB_ORD_HI];
   assign hi_slot  = (byte_idx == !hi_first);

   function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic idx, input logic hf);
      pick_byte = (idx == !hf) ? w[15:8] : w[7:0];
   endfunction

   always_comb begin
      next_state    = state;
      next_shreg    = shreg;
      next_bit_cnt  = bit_cnt;
      next_ctrl     = ctrl;
      next_row      = row;
      next_buffer   = buffer;
      next_byte_idx = byte_idx;
      next_wr_cnt   = wr_cnt;
      next_sda_oe   = sda_oe;
      prog_go       = 1'b0;
      tx_byte       = 8'h00;
      if (stop_det) begin
         next_state  = ST_IDLE;
         next_sda_oe = 1'b0;
         if (state == ST_WDATA && bit_cnt <= 4'h1 && (fill ? (wr_cnt == 2'h0) : (wr_cnt != 2'h0))) begin
            prog_go = 1'b1;
         end
      end else if (start_det) begin
         next_state   = ST_CTRL;
         next_bit_cnt = 4'h0;
         next_sda_oe  = 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               next_sda_oe = 1'b0;
            end
            ST_CTRL, ST_WDATA: begin
               if (scl_rise && bit_cnt != BYTE_BITS) begin
                  next_shreg   = {shreg[6:0], sda};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                  next_bit_cnt = 4'h0;
                  if (state == ST_CTRL) begin
                     next_wr_cnt   = 2'h0;
                     next_byte_idx = 1'b0;
                     if (busy) begin
                        next_state = ST_IDLE;
                     end else begin
                        next_ctrl   = shreg;
                        next_row    = shreg[7:CB_ROW_LSB];
                        next_buffer = rd_data;
                        next_sda_oe = 1'b1;
                        next_state  = ST_CACK;
                     end
                  end else if (!fill && wr_cnt != MAX_WR_BYTES) begin
                     if (hi_slot) next_buffer[15:8] = shreg;
                     else next_buffer[7:0] = shreg;
                     next_byte_idx = !byte_idx;
                     next_wr_cnt   = wr_cnt + 2'h1;
                     next_sda_oe   = 1'b1;
                     next_state    = ST_WACK;
                  end else begin
                     // a third byte or data after a fill code aborts the write
                     next_state = ST_IDLE;
                  end
               end
            end
            ST_CACK: begin
               if (scl_fall) begin
                  if (dir_bit) begin
                     tx_byte     = pick_byte(buffer, 1'b0, hi_first);
                     next_shreg  = tx_byte;
                     next_sda_oe = !tx_byte[7];
                     next_state  = ST_RDATA;
                  end else begin
                     next_sda_oe = 1'b0;
                     next_state  = ST_WDATA;
                  end
               end
            end
            ST_WACK: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  next_state  = ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (bit_cnt == LAST_TX_BIT) begin
                     next_bit_cnt = 4'h0;
                     next_sda_oe  = 1'b0;
                     next_state   = ST_RACK;
                  end else begin
                     next_bit_cnt = bit_cnt + 4'h1;
                     next_shreg   = {shreg[6:0], 1'b0};
                     next_sda_oe  = !shreg[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  if (sda) next_state = ST_IDLE;
                  else next_bit_cnt = 4'h1;
               end else if (scl_fall && bit_cnt == 4'h1) begin
                  next_bit_cnt = 4'h0;
                  if (byte_idx) begin
                     if (order == ORD_INC) next_row = row + 5'h01;
                     else if (order == ORD_DEC) next_row = row - 5'h01;
                     next_buffer   = rd_data;
                     next_byte_idx = 1'b0;
                     tx_byte       = pick_byte(rd_data, 1'b0, hi_first);
                  end else begin
                     next_byte_idx = 1'b1;
                     tx_byte       = pick_byte(buffer, 1'b1, hi_first);
                  end
                  next_shreg  = tx_byte;
                  next_sda_oe = !tx_byte[7];
                  next_state  = ST_RDATA;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state    <= ST_IDLE;
         shreg    <= 8'h00;
         bit_cnt  <= 4'h0;
         ctrl     <= 8'h00;
         row      <= '0;
         buffer   <= WORD_RESET;
         byte_idx <= 1'b0;
         wr_cnt   <= 2'h0;
         sda_oe   <= 1'b0;
      end else begin
         state    <= next_state;
         shreg    <= next_shreg;
         bit_cnt  <= next_bit_cnt;
         ctrl     <= next_ctrl;
         row      <= next_row;
         buffer   <= next_buffer;
         byte_idx <= next_byte_idx;
         wr_cnt   <= next_wr_cnt;
         sda_oe   <= next_sda_oe;
      end
   end

   // open drain: only ever pulls low
   assign sda_pin_out = 1'b0;
   assign sda_pin_oe  = sda_oe;
   assign prog_busy   = busy;

   // ****************************************
   // storage array
   // ****************************************
   // read address follows the next row so reloads see the new row at once
   sera_nv_array #(
      .ERASE_CYC (ERASE_CYC),
      .WRITE_CYC (WRITE_CYC)
   ) u_array (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .rd_row        (next_row),
      .rd_data       (rd_data),
      .prog_go       (prog_go),
      .prog_row      (row),
      .prog_data     (buffer),
      .prog_fill     (fill),
      .prog_fill_val (ctrl[CB_ORD_LO]),
      .busy          (busy)
   );

   // ****************************************
   // assertions
   // ****************************************
   property p_busy_nack;
      @(posedge ref_clk) disable iff (!rst_n)
      busy |-> !(state == ST_CACK);
   endproperty
   a_busy_nack: assert property (p_busy_nack) else $error("control byte acknowledged while busy");

   property p_stop_standby;
      @(posedge ref_clk) disable iff (!rst_n)
      stop_det |=> (state == ST_IDLE) && !sda_pin_oe;
   endproperty
   a_stop_standby: assert property (p_stop_standby) else $error("stop did not return to standby");

   property p_start_wake;
      @(posedge ref_clk) disable iff (!rst_n)
      start_det |=> (state == ST_CTRL) && (bit_cnt == 4'h0);
   endproperty
   a_start_wake: assert property (p_start_wake) else $error("start did not wake the interface");

   property p_prog_start;
      @(posedge ref_clk) disable iff (!rst_n)
      (stop_det && state == ST_WDATA && bit_cnt <= 4'h1 && !fill && wr_cnt != 2'h0) |=> busy;
   endproperty
   a_prog_start: assert property (p_prog_start) else $error("stop after data did not program");

   property p_nack_release;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_RACK && scl_rise && sda && !stop_det && !start_det)
         |=> (state == ST_IDLE) ##1 !sda_pin_oe;
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("kept sending after no acknowledge");

   property p_ctrl_load;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_CTRL && scl_fall && bit_cnt == BYTE_BITS && !busy)
         |=> (buffer == $past(rd_data)) && (row == $past(shreg[7:3])) && sda_pin_oe;
   endproperty
   a_ctrl_load: assert property (p_ctrl_load) else $error("row not loaded into buffer");

   property p_dir_select;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_CACK && scl_fall) |=> (state == (dir_bit ? ST_RDATA : ST_WDATA));
   endproperty
   a_dir_select: assert property (p_dir_select) else $error("direction bit not obeyed");

   property p_row_step;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_RACK && scl_fall && bit_cnt == 4'h1 && byte_idx && order == ORD_INC)
         |=> (row == $past(row) + 5'h01) && (buffer == $past(rd_data));
   endproperty
   a_row_step: assert property (p_row_step) else $error("auto increment row step wrong");

   property p_wr_limit;
      @(posedge ref_clk) disable iff (!rst_n)
      (state == ST_WDATA && scl_fall && bit_cnt == BYTE_BITS && wr_cnt == MAX_WR_BYTES)
         |=> (state == ST_IDLE) && !sda_pin_oe;
   endproperty
   a_wr_limit: assert property (p_wr_limit) else $error("third write byte acknowledged");

   c_write_prog: cover property (@(posedge ref_clk) disable iff (!rst_n) prog_go && !fill);
   c_read_inc:   cover property (@(posedge ref_clk) disable iff (!rst_n)
                                 state == ST_RACK && scl_fall && byte_idx && order == ORD_INC);
   c_busy_poll:  cover property (@(posedge ref_clk) disable iff (!rst_n)
                                 busy && state == ST_CTRL && scl_fall && bit_cnt == BYTE_BITS);
endmodule // sera_top
`default_nettype wire

// >>> sim/sera_master.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// two-wire bus master model
// ****************************************
module sera_master (
   // clock
   input  wire logic ref_clk,
   // bus
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask

   // scl low 5 clocks so the device answer is settled before the rise
   task automatic bitx(input logic b, output logic s);
      cyc(2);
      sda_low = !b;
      cyc(3);
      scl = 1'b1;
      cyc(3);
      s = sda_wire;
      scl = 1'b0;
   endtask

   task automatic start();
      cyc(2);
      sda_low = 1'b0;
      cyc(3);
      scl = 1'b1;
      cyc(4);
      sda_low = 1'b1;
      cyc(4);
      scl = 1'b0;
   endtask

   task automatic stop();
      cyc(2);
      sda_low = 1'b1;
      cyc(3);
      scl = 1'b1;
      cyc(4);
      sda_low = 1'b0;
      cyc(6);
   endtask

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(b[i], s);
      bitx(1'b1, s);
      ack = !s;
   endtask

   task automatic rbyte(output logic [7:0] b, input logic ack_it);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, s);
         b[i] = s;
      end
      bitx(!ack_it, s);
   endtask

   task automatic poll(output logic ack);
      start();
      wbyte(8'h00, ack);
      stop();
   endtask
endmodule // sera_master
`default_nettype wire

// >>> sim/sera_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sera_top_tb;
   import sera_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        scl;
   logic        sda_low;
   logic        sda_pin_oe;
   logic        sda_pin_out;
   logic        prog_busy;
   wire logic   sda_wire;
   logic [15:0] mem [ROWS];
   int          bad_count = 0;
   int          n_compared = 0;
   int          seed = 23427;

   always #12.5 ref_clk = ~ref_clk;
   // released line floats up through the pull-up
   assign sda_wire = !(sda_low || (sda_pin_oe && !sda_pin_out));

   sera_top #(.ERASE_CYC(60), .WRITE_CYC(60)) i_sera_top (
      .ref_clk(ref_clk), .rst_n(rst_n), .scl_pin(scl), .sda_pin_in(sda_wire),
      .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .prog_busy(prog_busy));
   sera_master i_sera_master (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

   // ****************************************
   // checking and transfers
   // ****************************************
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wr(input int r, input int o, input int n, input logic [15:0] d);
      logic a;
      logic prog;
      int   i;
      prog = (o >= 2) ? (n == 0) : (n == 1 || n == 2);
      i_sera_master.start();
      i_sera_master.wbyte({r[4:0], o[1:0], 1'b0}, a);
      chk("ctrl ack", a, 1);
      for (i = 0; i < n; i++) begin
         i_sera_master.wbyte(((i == 0) ^ (o == 1)) ? d[15:8] : d[7:0], a);
         chk("data ack", a, (o < 2 && i < 2));
      end
      i_sera_master.stop();
      chk("busy", prog_busy, prog);
      if (prog && o >= 2) foreach (mem[k]) mem[k] = {16{o[0]}};
      else if (prog) begin
         if (n == 2 || o == 0) mem[r][15:8] = d[15:8];
         if (n == 2 || o == 1) mem[r][7:0] = d[7:0];
      end
      i_sera_master.poll(a);
      chk("poll ack", a, !prog);
      for (i = 0; i < 20 && !a; i++) i_sera_master.poll(a);
      chk("ready ack", a, 1);
   endtask

   task automatic rd(input int r, input int o, input int n);
      logic       a;
      logic [7:0] b;
      int         w;
      i_sera_master.start();
      i_sera_master.wbyte({r[4:0], o[1:0], 1'b1}, a);
      chk("rd ack", a, 1);
      for (int k = 0; k < n; k++) begin
         i_sera_master.rbyte(b, k < n - 1);
         w = (r + ((o == 2) ? k / 2 : (o == 3) ? -(k / 2) : 0) + 32) % 32;
         chk("rd byte", b, ((k % 2 == 0) ^ (o == 1)) ? mem[w][15:8] : mem[w][7:0]);
      end
      i_sera_master.cyc(4);
      chk("released", sda_pin_oe, 0);
      i_sera_master.stop();
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      foreach (mem[k]) mem[k] = WORD_RESET;
      repeat (5) @(posedge ref_clk);
      #2 rst_n = 1'b1;
      i_sera_master.cyc(6);
      rd(31, 2, 4);
      wr(9, 3, 0, 16'h0000);
      rd(0, 3, 4);
      wr(4, 2, 1, 16'h0000);
      wr(4, 2, 0, 16'h0000);
      rd(4, 2, 3);
      for (int j = 0; j < 12; j++) begin
         wr($random(seed) & 31, (j / 4) % 2, j % 4, 16'($random(seed)));
         rd($random(seed) & 31, $random(seed) & 3, 1 + j % 4);
      end
      for (int r = 0; r < ROWS; r += 7) rd(r, 1, 2);
      close_out();
   end

   initial begin
      #2_000_000;
      bad_count++;
      close_out();
   end
endmodule // sera_top_tb
`default_nettype wire
